//--- design/sci_pkg.sv
// Purpose: Shared constants and types for the serial/LIN block
// Assumes: Byte registers on 32-bit Avalon-MM words
// Notes:   Offsets are byte addresses
package sci_pkg;
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_DATA   = 5'h04;
  localparam logic [4:0] ADDR_CTRL   = 5'h08;
  localparam logic [4:0] ADDR_CTRL3  = 5'h0c;
  localparam logic [4:0] ADDR_BAUD   = 5'h10;
  localparam logic [4:0] ADDR_ERX    = 5'h14;
  localparam logic [4:0] ADDR_ETX    = 5'h18;
  // Status bits
  localparam int ST_TXE = 7;
  localparam int ST_RXR = 5;
  localparam int ST_FE  = 1;
  localparam int ST_PE  = 0;
  // Control bits
  localparam int CR_WL  = 4;
  localparam int CR_PCE = 2;
  localparam int CR_SBK = 0;
  // Third control bits
  localparam int C3_LIN  = 6;
  localparam int C3_SLV  = 5;
  localparam int C3_ARS  = 4;
  localparam int C3_HDM  = 3;
  localparam int C3_HIE  = 2;
  localparam int C3_HDF  = 1;
  // Baud select fields
  localparam int FP_LO = 6;
  localparam int TD_LO = 3;
  localparam int RD_LO = 0;
  localparam logic [3:0] PR_DIV0 = 4'h1;
  localparam logic [3:0] PR_DIV1 = 4'h3;
  localparam logic [3:0] PR_DIV2 = 4'h4;
  localparam logic [3:0] PR_DIV3 = 4'hd;
  localparam logic [3:0] BREAK_BITS_LIN = 4'hd;
  localparam logic [3:0] BREAK_BITS_STD = 4'ha;
  localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
  localparam logic [7:0] BREAK_BYTE     = 8'h00;
  localparam logic [7:0] HDR_LEN_MAX    = 8'hff;
  localparam logic [22:0] LIN_MIN_CYC   = 23'h000010;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BREAK} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT_HIGH} rx_state_t;
  typedef enum logic [1:0] {HDR_NONE, HDR_SYNC, HDR_IDENT} hdr_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_t;

  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic        word_length;
    logic        parity_check_enable;
    logic        send_break;
    logic        lin_en;
    logic        slave_sel;
    logic        auto_resync;
    logic        hdr_method;
    logic        hdr_ie;
    logic        hdr_flag;
    logic        irq;
    logic [7:0]  baud;
    logic [7:0]  ext_rx;
    logic [7:0]  ext_tx;
    logic [7:0]  lin_mant;
    logic [3:0]  lin_frac;
    logic [7:0]  hdr_len;
    logic [22:0] hdr_cnt;
    logic        hdr_run;
    hdr_state_t  hdr_state;
    logic [7:0]  tx_buf;
    logic        tx_empty;
    tx_state_t   tx_state;
    logic [7:0]  tx_shift;
    logic [22:0] tx_cnt;
    logic [3:0]  tx_bits;
    logic        tx_line;
    logic [7:0]  rx_buf;
    logic        rx_ready;
    logic        fe;
    logic        pe;
    logic        st_seen;
    rx_state_t   rx_state;
    logic [7:0]  rx_shift;
    logic [22:0] rx_cnt;
    logic [3:0]  rx_bits;
    logic        rx_prev;
  } state_t;

  localparam state_t RESET_STATE = '{waitreq: 1'b1, tx_line: 1'b1, tx_empty: 1'b1,
    rx_prev: 1'b1, tx_state: TX_IDLE, rx_state: RX_IDLE, hdr_state: HDR_NONE, default: '0};
endpackage

//--- design/sci_lin.sv
// Purpose: Serial data path, baud generators and LIN header handling
// Assumes: Avalon-MM slave, 8-bit frames, inputs synchronous to clock_in
// Notes on behaviour
// - Data address: writes transmit, reads receive buffer
// - First prescaler divides by 1, 3, 4, 13
// - Transmit divisor is two to field value
// - Receive divisor is two to field value
// - Nonzero extended receive factor divides further
// - Nonzero extended transmit factor divides further
// - LIN slave uses one common LIN generator
// - LIN mode remaps length, mantissa, fraction addresses
// - LIN master break is 13 low bits
// - Break request ignored in LIN slave mode
// - Break-detect mode posts 0x00 and header flag
// - Header interrupt needs enable and clear mask
// - Synch field dropped when auto-resync enabled
// - Slave framing error excludes break characters
// - Identifier mode flags only after whole header
// - No transfer to data register during synch in identifier mode or with resync
// - Slave with parity enable checks identifier
// - Identifier top two bits are parity
// - LIN bit time is 16 times divider, never under 16 clocks
`timescale 1ns/1ns
module sci_lin (
  input  wire logic              clock_in,
  input  wire logic              reset_n_in,
  input  wire sci_pkg::avs_req_t avs_req_in,
  output logic                   avs_waitrequest_out,
  output logic [31:0]            avs_readdata_out,
  input  wire logic              rx_in,
  output logic                   tx_out,
  input  wire logic [1:0]        cpu_irq_mask_in,
  output logic                   header_irq_out
);
  sci_pkg::state_t s;
  sci_pkg::state_t n;
  logic        go_wr;
  logic        go_rd;
  logic        lin_slave;
  logic [22:0] tx_cyc;
  logic [22:0] rx_cyc;
  logic [22:0] lin_cyc;
  logic        tx_end;
  logic        rx_end;
  logic [7:0]  rd_byte;
  logic [3:0]  brk_len;
  logic        frame_done;
  logic        is_break;
  logic        post_it;
  logic        par0;
  logic        par1;
  logic        hdr_set;

  // Cycles per bit: 16 x prescaler x 2^divisor x optional extended factor
  function automatic logic [22:0] conv_cycles(input logic [1:0] fp,
                                              input logic [2:0] dv,
                                              input logic [7:0] ext);
    logic [10:0] base;
    logic [18:0] scaled;
    case (fp)
      2'h0: base = {7'h00, sci_pkg::PR_DIV0};
      2'h1: base = {7'h00, sci_pkg::PR_DIV1};
      2'h2: base = {7'h00, sci_pkg::PR_DIV2};
      default: base = {7'h00, sci_pkg::PR_DIV3};
    endcase
    base = base << dv;
    scaled = (ext == 8'h00) ? {8'h00, base} : ({8'h00, base} * {11'h000, ext});
    conv_cycles = {scaled, 4'h0};
  endfunction

  always_comb begin
    lin_slave = s.lin_en & s.slave_sel;
    // Bit time 16 x (mantissa + fraction/16) clocks, never under 16
    lin_cyc = {11'h000, s.lin_mant, s.lin_frac};
    if (lin_cyc < sci_pkg::LIN_MIN_CYC) begin
      lin_cyc = sci_pkg::LIN_MIN_CYC;
    end
    if (lin_slave) begin
      tx_cyc = lin_cyc;
      rx_cyc = lin_cyc;
    end else begin
      tx_cyc = conv_cycles(s.baud[sci_pkg::FP_LO +: 2], s.baud[sci_pkg::TD_LO +: 3],
                           s.ext_tx);
      rx_cyc = conv_cycles(s.baud[sci_pkg::FP_LO +: 2], s.baud[sci_pkg::RD_LO +: 3],
                           s.ext_rx);
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (avs_req_in.address)
      sci_pkg::ADDR_STATUS: begin
        rd_byte[sci_pkg::ST_TXE] = s.tx_empty;
        rd_byte[sci_pkg::ST_RXR] = s.rx_ready;
        rd_byte[sci_pkg::ST_FE]  = s.fe;
        rd_byte[sci_pkg::ST_PE]  = s.pe;
      end
      sci_pkg::ADDR_DATA: rd_byte = s.rx_buf;
      sci_pkg::ADDR_CTRL: begin
        rd_byte[sci_pkg::CR_WL]  = s.word_length;
        rd_byte[sci_pkg::CR_PCE] = s.parity_check_enable;
        rd_byte[sci_pkg::CR_SBK] = s.send_break;
      end
      sci_pkg::ADDR_CTRL3: begin
        rd_byte[sci_pkg::C3_LIN] = s.lin_en;
        rd_byte[sci_pkg::C3_SLV] = s.slave_sel;
        rd_byte[sci_pkg::C3_ARS] = s.auto_resync;
        rd_byte[sci_pkg::C3_HDM] = s.hdr_method;
        rd_byte[sci_pkg::C3_HIE] = s.hdr_ie;
        rd_byte[sci_pkg::C3_HDF] = s.hdr_flag;
      end
      sci_pkg::ADDR_BAUD: rd_byte = s.lin_en ? s.lin_mant : s.baud;
      sci_pkg::ADDR_ERX:  rd_byte = s.lin_en ? s.hdr_len : s.ext_rx;
      sci_pkg::ADDR_ETX:  rd_byte = s.lin_en ? {4'h0, s.lin_frac} : s.ext_tx;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    n = s;
    go_wr = avs_req_in.write & ~s.waitreq & avs_req_in.byteenable[0];
    go_rd = avs_req_in.read & ~s.waitreq;
    frame_done = 1'b0;
    is_break = 1'b0;
    post_it = 1'b0;
    par0 = 1'b0;
    par1 = 1'b0;
    hdr_set = 1'b0;
    brk_len = s.lin_en ? sci_pkg::BREAK_BITS_LIN : sci_pkg::BREAK_BITS_STD;
    tx_end = s.tx_cnt >= tx_cyc - 23'h000001;
    rx_end = s.rx_cnt >= rx_cyc - 23'h000001;
    // Wait one cycle, then answer for one cycle
    n.waitreq = ~((avs_req_in.read | avs_req_in.write) & s.waitreq);
    if (s.waitreq & avs_req_in.read) begin
      n.rdata = {24'h000000, rd_byte};
    end

    // Flag clear: status read then data read
    if (go_rd && avs_req_in.address == sci_pkg::ADDR_STATUS) begin
      n.st_seen = 1'b1;
    end
    if (go_rd && avs_req_in.address == sci_pkg::ADDR_DATA && s.st_seen) begin
      n.st_seen = 1'b0;
      n.rx_ready = 1'b0;
      n.fe = 1'b0;
      n.pe = 1'b0;
    end

    // Transmitter
    n.tx_cnt = s.tx_cnt + 23'h000001;
    case (s.tx_state)
      sci_pkg::TX_IDLE: begin
        n.tx_cnt = '0;
        n.tx_line = 1'b1;
        if (s.send_break && !lin_slave) begin
          n.tx_state = sci_pkg::TX_BREAK;
          n.tx_line = 1'b0;
          n.tx_bits = '0;
        end else if (!s.tx_empty) begin
          n.tx_shift = s.tx_buf;
          n.tx_empty = 1'b1;
          n.tx_state = sci_pkg::TX_START;
          n.tx_line = 1'b0;
        end
      end
      sci_pkg::TX_START: begin
        if (tx_end) begin
          n.tx_cnt = '0;
          n.tx_bits = '0;
          n.tx_state = sci_pkg::TX_DATA;
          n.tx_line = s.tx_shift[0];
        end
      end
      sci_pkg::TX_DATA: begin
        if (tx_end) begin
          n.tx_cnt = '0;
          if (s.tx_bits == sci_pkg::LAST_DATA_BIT) begin
            n.tx_state = sci_pkg::TX_STOP;
            n.tx_line = 1'b1;
          end else begin
            n.tx_shift = {1'b0, s.tx_shift[7:1]};
            n.tx_bits = s.tx_bits + 4'h1;
            n.tx_line = s.tx_shift[1];
          end
        end
      end
      sci_pkg::TX_BREAK: begin
        if (tx_end) begin
          n.tx_cnt = '0;
          n.tx_bits = s.tx_bits + 4'h1;
          if (s.tx_bits == brk_len - 4'h1) begin
            n.tx_state = sci_pkg::TX_STOP;
            n.tx_line = 1'b1;
          end
        end
      end
      sci_pkg::TX_STOP: begin
        if (tx_end) begin
          n.tx_state = sci_pkg::TX_IDLE;
        end
      end
      default: n.tx_state = sci_pkg::TX_IDLE;
    endcase

    // Header length in bit times
    if (s.hdr_run) begin
      n.hdr_cnt = s.hdr_cnt + 23'h000001;
      if (s.hdr_cnt >= rx_cyc - 23'h000001) begin
        n.hdr_cnt = '0;
        if (s.hdr_len != sci_pkg::HDR_LEN_MAX) begin
          n.hdr_len = s.hdr_len + 8'h01;
        end
      end
    end

    // Receiver, sampling at mid bit
    n.rx_prev = rx_in;
    n.rx_cnt = s.rx_cnt + 23'h000001;
    case (s.rx_state)
      sci_pkg::RX_IDLE: begin
        n.rx_cnt = '0;
        if (s.rx_prev && !rx_in) begin
          n.rx_state = sci_pkg::RX_START;
        end
      end
      sci_pkg::RX_START: begin
        if (s.rx_cnt >= {1'b0, rx_cyc[22:1]}) begin
          n.rx_cnt = '0;
          n.rx_bits = '0;
          n.rx_state = rx_in ? sci_pkg::RX_IDLE : sci_pkg::RX_DATA;
        end
      end
      sci_pkg::RX_DATA: begin
        if (rx_end) begin
          n.rx_cnt = '0;
          n.rx_shift = {rx_in, s.rx_shift[7:1]};
          n.rx_bits = s.rx_bits + 4'h1;
          if (s.rx_bits == sci_pkg::LAST_DATA_BIT) begin
            n.rx_state = sci_pkg::RX_STOP;
          end
        end
      end
      sci_pkg::RX_STOP: begin
        if (rx_end) begin
          frame_done = 1'b1;
          n.rx_state = rx_in ? sci_pkg::RX_IDLE : sci_pkg::RX_WAIT_HIGH;
        end
      end
      sci_pkg::RX_WAIT_HIGH: begin
        if (rx_in) begin
          n.rx_state = sci_pkg::RX_IDLE;
        end
      end
      default: n.rx_state = sci_pkg::RX_IDLE;
    endcase

    if (frame_done) begin
      is_break = (s.rx_shift == sci_pkg::BREAK_BYTE) && !rx_in;
      post_it = 1'b1;
      if (lin_slave && is_break) begin
        // Break in slave: no framing error, header starts
        post_it = 1'b0;
        n.hdr_state = sci_pkg::HDR_SYNC;
        n.hdr_run = 1'b1;
        n.hdr_len = '0;
        n.hdr_cnt = '0;
        if (!s.hdr_method) begin
          n.rx_buf = sci_pkg::BREAK_BYTE;
          n.rx_ready = 1'b1;
          n.hdr_flag = 1'b1;
          hdr_set = 1'b1;
        end
      end else if (lin_slave && s.hdr_state == sci_pkg::HDR_SYNC) begin
        // Measured synch field reaches the buffer only without resync
        post_it = !s.hdr_method && !s.auto_resync;
        n.hdr_state = sci_pkg::HDR_IDENT;
      end else if (lin_slave && s.hdr_state == sci_pkg::HDR_IDENT) begin
        n.hdr_state = sci_pkg::HDR_NONE;
        n.hdr_run = 1'b0;
        if (s.hdr_method) begin
          n.hdr_flag = 1'b1;
          hdr_set = 1'b1;
        end
        par0 = s.rx_shift[0] ^ s.rx_shift[1] ^ s.rx_shift[2] ^ s.rx_shift[4];
        par1 = ~(s.rx_shift[1] ^ s.rx_shift[3] ^ s.rx_shift[4] ^ s.rx_shift[5]);
        if (s.parity_check_enable && (s.rx_shift[7:6] != {par1, par0})) begin
          n.pe = 1'b1;
        end
      end
      if (post_it) begin
        n.rx_buf = s.rx_shift;
        n.rx_ready = 1'b1;
        if (!rx_in) begin
          n.fe = 1'b1;
        end
      end
    end

    // Register writes; a header flag set above wins over its clear, but a data write overrides the tx_empty set
    if (go_wr) begin
      case (avs_req_in.address)
        sci_pkg::ADDR_DATA: begin
          n.tx_buf = avs_req_in.writedata[7:0];
          n.tx_empty = 1'b0;
        end
        sci_pkg::ADDR_CTRL: begin
          n.word_length = avs_req_in.writedata[sci_pkg::CR_WL];
          n.parity_check_enable = avs_req_in.writedata[sci_pkg::CR_PCE];
          n.send_break = avs_req_in.writedata[sci_pkg::CR_SBK];
        end
        sci_pkg::ADDR_CTRL3: begin
          n.lin_en = avs_req_in.writedata[sci_pkg::C3_LIN];
          n.slave_sel = avs_req_in.writedata[sci_pkg::C3_SLV];
          n.auto_resync = avs_req_in.writedata[sci_pkg::C3_ARS];
          n.hdr_method = avs_req_in.writedata[sci_pkg::C3_HDM];
          n.hdr_ie = avs_req_in.writedata[sci_pkg::C3_HIE];
          // Writing 0 clears; a detection in the same cycle still wins
          n.hdr_flag = hdr_set | (s.hdr_flag & avs_req_in.writedata[sci_pkg::C3_HDF]);
        end
        sci_pkg::ADDR_BAUD: begin
          if (s.lin_en) begin
            n.lin_mant = avs_req_in.writedata[7:0];
          end else begin
            n.baud = avs_req_in.writedata[7:0];
          end
        end
        sci_pkg::ADDR_ERX: begin
          if (!s.lin_en) begin
            n.ext_rx = avs_req_in.writedata[7:0];
          end
        end
        sci_pkg::ADDR_ETX: begin
          if (s.lin_en) begin
            n.lin_frac = avs_req_in.writedata[3:0];
          end else begin
            n.ext_tx = avs_req_in.writedata[7:0];
          end
        end
        default: n.tx_buf = s.tx_buf;
      endcase
    end

    n.irq = s.hdr_flag & s.hdr_ie & (cpu_irq_mask_in == 2'h0);
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      s <= sci_pkg::RESET_STATE;
    end else begin
      s <= n;
    end
  end

  assign avs_waitrequest_out = s.waitreq;
  assign avs_readdata_out    = s.rdata;
  assign tx_out              = s.tx_line;
  assign header_irq_out      = s.irq;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_data_wr;
    go_wr && avs_req_in.address == sci_pkg::ADDR_DATA
      |=> s.tx_buf == $past(avs_req_in.writedata[7:0]) && !s.tx_empty;
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data write lost");
  property p_data_rd;
    s.waitreq && avs_req_in.read && avs_req_in.address == sci_pkg::ADDR_DATA
      |=> avs_readdata_out == {24'h000000, $past(s.rx_buf)};
  endproperty
  a_data_rd: assert property (p_data_rd) else $error("data read wrong");
  property p_fp13;
    !lin_slave && s.baud == 8'hf8 && s.ext_tx == 8'h00 |-> tx_cyc == 23'h006800;
  endproperty
  a_fp13: assert property (p_fp13) else $error("tx divide 13x128 wrong");
  property p_rx_div;
    !lin_slave && s.baud == 8'h47 && s.ext_rx == 8'h00 |-> rx_cyc == 23'h001800;
  endproperty
  a_rx_div: assert property (p_rx_div) else $error("rx divide 3x128 wrong");
  property p_ext_tx;
    !lin_slave && s.baud == 8'h00 && s.ext_tx == 8'hff |-> tx_cyc == 23'h000ff0;
  endproperty
  a_ext_tx: assert property (p_ext_tx) else $error("ext tx divide wrong");
  property p_lin_gen;
    lin_slave && s.lin_mant != 8'h00 |-> tx_cyc == rx_cyc && tx_cyc[11:0] == {s.lin_mant,
      s.lin_frac};
  endproperty
  a_lin_gen: assert property (p_lin_gen) else $error("lin generator not used");
  property p_no_slave_brk;
    lin_slave && s.tx_state == sci_pkg::TX_IDLE |=> s.tx_state != sci_pkg::TX_BREAK;
  endproperty
  a_no_slave_brk: assert property (p_no_slave_brk) else $error("slave sent break");
  property p_brk13;
    s.tx_state == sci_pkg::TX_BREAK && s.lin_en && tx_end && s.tx_bits == 4'hc
      |=> s.tx_state == sci_pkg::TX_STOP && tx_out;
  endproperty
  a_brk13: assert property (p_brk13) else $error("lin break not 13 bits");
  property p_brk_low;
    s.tx_state == sci_pkg::TX_BREAK |-> !tx_out;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break not low");
  property p_hdr_brk;
    frame_done && is_break && lin_slave && !s.hdr_method
      |=> s.rx_ready && s.hdr_flag && s.rx_buf == 8'h00 && (!s.fe || $past(s.fe));
  endproperty
  a_hdr_brk: assert property (p_hdr_brk) else $error("break header not posted");
  property p_irq;
    header_irq_out |-> $past(s.hdr_flag && s.hdr_ie && cpu_irq_mask_in == 2'h0);
  endproperty
  a_irq: assert property (p_irq) else $error("header irq without cause");
  property p_sync_drop;
    frame_done && lin_slave && s.hdr_state == sci_pkg::HDR_SYNC && s.auto_resync
      |=> s.rx_buf == $past(s.rx_buf);
  endproperty
  a_sync_drop: assert property (p_sync_drop) else $error("synch reached buffer");
  c_break: cover property (s.tx_state == sci_pkg::TX_BREAK && s.lin_en);
  c_header: cover property (lin_slave && s.hdr_method && $rose(s.hdr_flag));
  c_parity: cover property ($rose(s.pe));
endmodule

//--- testbench/lin_node.sv
// Purpose: Remote serial/LIN node on the far side of the link
// Assumes: Bit times in clock cycles, line pulled up when released
// Notes:   Frames are sent and captured through tasks
`timescale 1ns/1ns
module lin_node (
  input  wire logic clock_in,
  input  wire logic tx_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // Sends n bits LSB first, then releases the line to idle high
  task automatic send(input logic [15:0] bits, input int n, input int bit_cyc);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (bit_cyc) @(posedge clock_in);
    end
    line_out <= 1'b1;
  endtask

  // Start bit length gives the bit time, so data LSB must be 1
  task automatic measure(output logic [7:0] data, output int low_cyc);
    low_cyc = 0;
    do @(posedge clock_in); while (tx_in !== 1'b0);
    while (tx_in === 1'b0) begin
      low_cyc++;
      @(posedge clock_in);
    end
    repeat (low_cyc / 2) @(posedge clock_in);
    for (int i = 0; i < 8; i++) begin
      data[i] = tx_in;
      repeat (low_cyc) @(posedge clock_in);
    end
  endtask
endmodule

//--- testbench/tb.sv
// Purpose: Self-checking bench for the serial/LIN block
// Assumes: Byte registers on Avalon-MM, remote node model on the link
// Notes:   Random bytes from a fixed seed, corner cases by hand
`timescale 1ns/1ns
module tb;
  logic              clock_in;
  logic              reset_n_in;
  sci_pkg::avs_req_t req;
  logic              waitreq;
  logic [31:0]       rdata;
  logic              rx_line;
  logic              tx_line;
  logic [1:0]        mask;
  logic              irq;
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                cycles = 0;
  int                seed = 32'h11355dc3;
  int                len;
  logic [7:0]        q;
  logic [7:0]        d;
  logic [7:0]        id;
  logic [7:0]        baud_tab [4] = '{8'h00, 8'h4a, 8'h91, 8'hc8};
  logic [7:0]        ext_tab [4] = '{8'h00, 8'h00, 8'h03, 8'h02};

  sci_lin dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .avs_req_in(req),
    .avs_waitrequest_out(waitreq), .avs_readdata_out(rdata), .rx_in(rx_line),
    .tx_out(tx_line), .cpu_irq_mask_in(mask), .header_irq_out(irq));
  lin_node node (.clock_in(clock_in), .tx_in(tx_line), .line_out(rx_line));

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 80000) begin
      n_mismatch++;
      stop_test;
    end
  end

  // One access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    req.read <= ~w;
    req.write <= w;
    req.address <= a;
    req.writedata <= {24'h000000, wd};
    req.byteenable <= 4'hf;
    do @(posedge clock_in); while (waitreq !== 1'b0);
    rd = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, a, 8'h00, v);
    check({24'h0, v}, {24'h0, exp});
  endtask

  function automatic int bt(input logic [1:0] fp, input logic [2:0] dv, input logic [7:0] ex);
    int pr;
    pr = (fp == 2'b00) ? 1 : (fp == 2'b01) ? 3 : (fp == 2'b10) ? 4 : 13;
    return 16 * pr * (1 << dv) * ((ex == 8'h00) ? 1 : int'(ex));
  endfunction

  function automatic logic [7:0] par(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction

  task automatic tx_chk(input int b);
    logic [7:0] got;
    int         low;
    d = 8'($random(seed)) | 8'h01;
    fork
      node.measure(got, low);
      wr(sci_pkg::ADDR_DATA, d);
    join
    check(32'(low), 32'(b));
    check({24'h0, got}, {24'h0, d});
  endtask

  task automatic rx_chk(input int b);
    d = 8'($random(seed));
    node.send({7'h7f, d, 1'b0}, 10, b);
    repeat (4) @(posedge clock_in);
    rd_chk(sci_pkg::ADDR_STATUS, 8'ha0);
    rd_chk(sci_pkg::ADDR_DATA, d);
  endtask

  initial begin
    req = '0;
    mask = 2'b00;
    reset_n_in = 1'b0;
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    rd_chk(sci_pkg::ADDR_STATUS, 8'h80);
    rd_chk(sci_pkg::ADDR_BAUD, 8'h00);
    rd_chk(sci_pkg::ADDR_ERX, 8'h00);
    rd_chk(sci_pkg::ADDR_ETX, 8'h00);
    wr(5'h1c, 8'h5a);
    rd_chk(5'h1c, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      wr(5'h10 + 5'(4 * i), d);
      rd_chk(5'h10 + 5'(4 * i), d);
    end
    // Extreme divider settings, bit times watched by the design's assertions
    wr(sci_pkg::ADDR_ETX, 8'h00);
    wr(sci_pkg::ADDR_ERX, 8'h00);
    wr(sci_pkg::ADDR_BAUD, 8'hf8);
    wr(sci_pkg::ADDR_BAUD, 8'h47);
    rd_chk(sci_pkg::ADDR_BAUD, 8'h47);
    wr(sci_pkg::ADDR_BAUD, 8'h00);
    wr(sci_pkg::ADDR_ETX, 8'hff);
    rd_chk(sci_pkg::ADDR_ETX, 8'hff);
    wr(sci_pkg::ADDR_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(sci_pkg::ADDR_ERX, ext_tab[i]);
      wr(sci_pkg::ADDR_ETX, ext_tab[i]);
      wr(sci_pkg::ADDR_BAUD, baud_tab[i]);
      tx_chk(bt(baud_tab[i][7:6], baud_tab[i][5:3], ext_tab[i]));
      rx_chk(bt(baud_tab[i][7:6], baud_tab[i][2:0], ext_tab[i]));
    end
    // Master break: send_break set then cleared at once
    wr(sci_pkg::ADDR_ERX, 8'h00);
    wr(sci_pkg::ADDR_ETX, 8'h00);
    wr(sci_pkg::ADDR_BAUD, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(sci_pkg::ADDR_CTRL3, m ? 8'h40 : 8'h00);
      fork
        node.measure(d, len);
        begin
          wr(sci_pkg::ADDR_CTRL, 8'h01);
          wr(sci_pkg::ADDR_CTRL, 8'h00);
        end
      join
      check(32'(len), m ? 32'd208 : 32'd160);
    end
    // Synch byte after the break, then let the frame end
    fork
      node.measure(id, len);
      wr(sci_pkg::ADDR_DATA, 8'h55);
    join
    check(32'(len), 32'd16);
    check({24'h0, id}, 32'h55);
    repeat (30) @(posedge clock_in);
    rd_chk(sci_pkg::ADDR_STATUS, 8'h80);
    // Slave mode, divider 2 + 3/16 gives 35 clocks a bit
    wr(sci_pkg::ADDR_CTRL3, 8'h60);
    wr(sci_pkg::ADDR_BAUD, 8'h02);
    wr(sci_pkg::ADDR_ETX, 8'h03);
    rd_chk(sci_pkg::ADDR_BAUD, 8'h02);
    wr(sci_pkg::ADDR_CTRL, 8'h01);
    len = 0;
    repeat (600) begin
      @(posedge clock_in);
      if (tx_line !== 1'b1) len++;
    end
    check(32'(len), 32'd0);
    wr(sci_pkg::ADDR_CTRL, 8'h04);
    tx_chk(35);
    for (int k = 0; k < 2; k++) begin
      id = par(6'($random(seed))) ^ {k[0], 7'h00};
      wr(sci_pkg::ADDR_CTRL3, k ? 8'h64 : 8'h74);
      node.send(16'h2000, 14, 35);
      rd_chk(sci_pkg::ADDR_STATUS, 8'ha0);
      rd_chk(sci_pkg::ADDR_DATA, 8'h00);
      rd_chk(sci_pkg::ADDR_CTRL3, k ? 8'h66 : 8'h76);
      check({31'h0, irq}, 32'h1);
      mask <= {k[0], ~k[0]};
      repeat (3) @(posedge clock_in);
      check({31'h0, irq}, 32'h0);
      mask <= 2'b00;
      wr(sci_pkg::ADDR_CTRL3, k ? 8'h64 : 8'h74);
      node.send({7'h7f, 8'h55, 1'b0}, 10, 35);
      rd_chk(sci_pkg::ADDR_STATUS, k ? 8'ha0 : 8'h80);
      rd_chk(sci_pkg::ADDR_DATA, k ? 8'h55 : 8'h00);
      node.send({7'h7f, id, 1'b0}, 10, 35);
      rd_chk(sci_pkg::ADDR_STATUS, k ? 8'ha1 : 8'ha0);
      rd_chk(sci_pkg::ADDR_DATA, id);
    end
    wr(sci_pkg::ADDR_CTRL3, 8'h6c);
    node.send(16'h2000, 14, 35);
    node.send({7'h7f, 8'h55, 1'b0}, 10, 35);
    rd_chk(sci_pkg::ADDR_CTRL3, 8'h6c);
    rd_chk(sci_pkg::ADDR_STATUS, 8'h80);
    id = par(6'($random(seed)));
    node.send({7'h7f, id, 1'b0}, 10, 35);
    rd_chk(sci_pkg::ADDR_CTRL3, 8'h6e);
    check({31'h0, irq}, 32'h1);
    rd_chk(sci_pkg::ADDR_STATUS, 8'ha0);
    rd_chk(sci_pkg::ADDR_DATA, id);
    // Non-break frame with a low stop bit
    wr(sci_pkg::ADDR_CTRL3, 8'h60);
    node.send({7'h7e, 8'h3c, 1'b0}, 10, 35);
    repeat (40) @(posedge clock_in);
    rd_chk(sci_pkg::ADDR_STATUS, 8'ha2);
    rd_chk(sci_pkg::ADDR_DATA, 8'h3c);
    stop_test;
  end
endmodule
